// File: rtl/dgc_pkg.sv
// constants for the digitizer interrupt and acquisition register bank
package dgc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_ICFG = 8'h08;
  localparam logic [7:0] OFS_ICTL = 8'h0c;
  localparam logic [7:0] OFS_ACQ = 8'h10;
  localparam logic [7:0] OFS_SDLY = 8'h14;
  localparam logic [7:0] OFS_PDLY = 8'h18;
  localparam logic [7:0] OFS_RESET = 8'h20;
  // interrupt control fields
  localparam int ICTL_STAT_LSB = 28;
  localparam int ICTL_BUSIRQ = 27;
  localparam int ICTL_INTIRQ = 26;
  localparam int ICTL_DIS_LSB = 16;
  localparam int ICTL_EN_LSB = 0;
  localparam logic [31:0] ICTL_RESET = 32'h00000000;
  // interrupt configuration fields
  localparam int ICFG_MODE = 12;
  localparam int ICFG_GEN = 11;
  localparam int ICFG_LVL_LSB = 8;
  localparam logic [12:0] ICFG_RESET = 13'h0000;
  // acquisition set/clear layout
  localparam int ACQ_CLR_OFS = 16;
  localparam int ACQ_CLK_LSB = 12;
  localparam int ACQ_GATE = 10;
  localparam int ACQ_BPSS = 9;
  localparam int ACQ_FPSS = 8;
  localparam int ACQ_SDLY = 7;
  localparam int ACQ_PDLY = 6;
  localparam int ACQ_MULTI = 5;
  localparam int ACQ_AUTO = 4;
  localparam int ACQ_ARM2 = 1;
  localparam int ACQ_ARM1 = 0;
  localparam int ACQ_BUSY = 16;
  localparam logic [15:0] ACQ_IMPL = 16'h77f3;
  localparam logic [15:0] ACQ_RESET = 16'h0000;
  // extra clocks added to each external delay
  localparam logic [16:0] DLY_EXTRA = 17'h00002;
  // interrupt source indices
  localparam int SRC_EVENT = 0;
  localparam int SRC_BANK = 1;
  localparam int SRC_USER = 3;
endpackage

// File: rtl/dgc_edge_delay.sv
// delays an edge pulse by a programmed count plus a fixed extra
`timescale 1ns/1ps
`default_nettype none
module dgc_edge_delay (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire logic [15:0] delayVal,
  // edge pulse in and out
  input wire logic edgeIn,
  output logic edgeOut
);
  logic [16:0] cnt_ff, nxt_cnt;
  logic busy_ff, nxt_busy;
  logic out_ff, nxt_out;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    nxt_out = 1'b0;
    if (!enable) begin
      nxt_busy = 1'b0;
      nxt_out = edgeIn;
    end else if (busy_ff) begin
      if (cnt_ff <= 17'h00001) begin
        nxt_busy = 1'b0;
        nxt_out = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - 17'h00001;
      end
    end else if (edgeIn) begin
      // value plus two clocks in total
      nxt_cnt = {1'b0, delayVal} + dgc_pkg::DLY_EXTRA - 17'h00001;
      nxt_busy = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 17'h00000;
      busy_ff <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
      out_ff <= nxt_out;
    end
  end

  assign edgeOut = out_ff;
endmodule
`default_nettype wire

// File: rtl/dgc_regs.sv
// interrupt control and acquisition control register bank
// Behaviour
// - four interrupt sources, source two never fires
// - status bits 31..26 report pending and irq
// - ones at bits 19..16 disable sources
// - ones at bits 3..0 enable, read back
// - interrupt control reads zero after reset
// - acquisition register is set/clear pair
// - clock source set 14..12, clear 30..28
// - clock codes pick internal rates or external
// - gate mode set bit 10, clear 26
// - start/stop logic bits 9/25 and 8/24
// - start/stop delay enables bits 7/23, 6/22
// - multi event set bit 5, clear 21
// - disarm at event end (single) or bank end (multi event)
// - autostart bit 4/20, only in multi event
// - bank arm bits 0,1; disarm 16,17
// - bit 16 reads busy flag
// - write to reset key resets everything but the read data register
// - release on access or on acknowledge
// - global enable, level and vector fields
// - delay edges by register value plus two
`timescale 1ns/1ps
`default_nettype none
module dgc_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  // interrupt request and acknowledge
  input wire logic irqAck,
  output logic irqReq,
  output logic [2:0] irqLevel,
  output logic [7:0] irqVector,
  // acquisition events
  input wire logic eventEnd,
  input wire logic bankEnd,
  input wire logic userIn,
  input wire logic adcBusy,
  input wire logic extStart,
  input wire logic extStop,
  // acquisition controls
  output logic [2:0] clockSource,
  output logic gateMode,
  output logic backplaneStartStop,
  output logic frontStartStop,
  output logic multiEvent,
  output logic autoStart,
  output logic [1:0] bankArm,
  output logic startOut,
  output logic stopOut
);
  logic [3:0] irqEn_ff, nxt_irqEn;
  logic [3:0] irqPend_ff, nxt_irqPend;
  logic [12:0] icfg_ff, nxt_icfg;
  logic [15:0] acq_ff, nxt_acq;
  logic [15:0] sdly_ff, nxt_sdly;
  logic [15:0] pdly_ff, nxt_pdly;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [3:0] srcHit;
  logic [3:0] active;
  logic anyActive;
  logic keyReset;

  function automatic logic wrAt(input logic [7:0] ofs);
    wrAt = regWr && (regAddr == ofs);
  endfunction

  // module reset key
  // key resets all but the read data register
  assign keyReset = wrAt(dgc_pkg::OFS_RESET);

  assign srcHit = {userIn, 1'b0, bankEnd, eventEnd};
  assign active = irqPend_ff & irqEn_ff;
  assign anyActive = |active;

  // interrupt state
  always_comb begin
    nxt_irqEn = irqEn_ff;
    nxt_irqPend = irqPend_ff;
    nxt_icfg = icfg_ff;
    if (wrAt(dgc_pkg::OFS_ICFG)) begin
      nxt_icfg = regWdata[12:0];
    end
    if (wrAt(dgc_pkg::OFS_ICTL)) begin
      nxt_irqEn = nxt_irqEn | regWdata[dgc_pkg::ICTL_EN_LSB +: 4];
      nxt_irqEn = nxt_irqEn & ~regWdata[dgc_pkg::ICTL_DIS_LSB +: 4];
      nxt_irqPend = nxt_irqPend & ~regWdata[dgc_pkg::ICTL_DIS_LSB +: 4];
    end
    if (irqAck && icfg_ff[dgc_pkg::ICFG_MODE]) begin
      nxt_irqPend = nxt_irqPend & ~active;
      nxt_irqEn = nxt_irqEn & ~active;
    end
    // new events win over clears
    nxt_irqPend = nxt_irqPend | srcHit;
  end

  always_ff @(posedge clk) begin
    if (rst || keyReset) begin
      irqEn_ff <= 4'h0;
      irqPend_ff <= 4'h0;
      icfg_ff <= dgc_pkg::ICFG_RESET;
    end else begin
      irqEn_ff <= nxt_irqEn;
      irqPend_ff <= nxt_irqPend;
      icfg_ff <= nxt_icfg;
    end
  end

  // acquisition state
  always_comb begin
    nxt_acq = acq_ff;
    nxt_sdly = sdly_ff;
    nxt_pdly = pdly_ff;
    if (wrAt(dgc_pkg::OFS_ACQ)) begin
      nxt_acq = nxt_acq | (regWdata[15:0] & dgc_pkg::ACQ_IMPL);
      nxt_acq = nxt_acq & ~regWdata[31:16];
    end
    if (wrAt(dgc_pkg::OFS_SDLY)) begin
      nxt_sdly = regWdata[15:0];
    end
    if (wrAt(dgc_pkg::OFS_PDLY)) begin
      nxt_pdly = regWdata[15:0];
    end
    if (acq_ff[dgc_pkg::ACQ_MULTI] ? bankEnd : eventEnd) begin
      nxt_acq[dgc_pkg::ACQ_ARM2:dgc_pkg::ACQ_ARM1] = 2'b00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || keyReset) begin
      acq_ff <= dgc_pkg::ACQ_RESET;
      sdly_ff <= 16'h0000;
      pdly_ff <= 16'h0000;
    end else begin
      acq_ff <= nxt_acq;
      sdly_ff <= nxt_sdly;
      pdly_ff <= nxt_pdly;
    end
  end

  // read data
  always_comb begin
    nxt_rdata = rdata_ff;
    if (regRd) begin
      if (regAddr == dgc_pkg::OFS_ICTL) begin
        nxt_rdata = 32'h00000000;
        nxt_rdata[dgc_pkg::ICTL_STAT_LSB +: 4] = irqPend_ff;
        nxt_rdata[dgc_pkg::ICTL_BUSIRQ] =
          anyActive & icfg_ff[dgc_pkg::ICFG_GEN];
        nxt_rdata[dgc_pkg::ICTL_INTIRQ] = anyActive;
        nxt_rdata[dgc_pkg::ICTL_EN_LSB +: 4] = irqEn_ff;
      end else if (regAddr == dgc_pkg::OFS_ICFG) begin
        nxt_rdata = {19'h00000, icfg_ff};
      end else if (regAddr == dgc_pkg::OFS_ACQ) begin
        nxt_rdata = {16'h0000, acq_ff};
        nxt_rdata[dgc_pkg::ACQ_BUSY] = adcBusy;
      end else if (regAddr == dgc_pkg::OFS_SDLY) begin
        nxt_rdata = {16'h0000, sdly_ff};
      end else if (regAddr == dgc_pkg::OFS_PDLY) begin
        nxt_rdata = {16'h0000, pdly_ff};
      end else begin
        nxt_rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  dgc_edge_delay uStartDly (
    .clk(clk),
    .rst(rst || keyReset),
    .enable(acq_ff[dgc_pkg::ACQ_SDLY]),
    .delayVal(sdly_ff),
    .edgeIn(extStart),
    .edgeOut(startOut)
  );

  dgc_edge_delay uStopDly (
    .clk(clk),
    .rst(rst || keyReset),
    .enable(acq_ff[dgc_pkg::ACQ_PDLY]),
    .delayVal(pdly_ff),
    .edgeIn(extStop),
    .edgeOut(stopOut)
  );

  assign regRdata = rdata_ff;
  assign irqReq = anyActive & icfg_ff[dgc_pkg::ICFG_GEN];
  assign irqLevel = icfg_ff[dgc_pkg::ICFG_LVL_LSB +: 3];
  assign irqVector = icfg_ff[7:0];
  assign clockSource = acq_ff[dgc_pkg::ACQ_CLK_LSB +: 3];
  assign gateMode = acq_ff[dgc_pkg::ACQ_GATE];
  assign backplaneStartStop = acq_ff[dgc_pkg::ACQ_BPSS];
  assign frontStartStop = acq_ff[dgc_pkg::ACQ_FPSS];
  assign multiEvent = acq_ff[dgc_pkg::ACQ_MULTI];
  assign autoStart = acq_ff[dgc_pkg::ACQ_AUTO] & acq_ff[dgc_pkg::ACQ_MULTI];
  assign bankArm = acq_ff[dgc_pkg::ACQ_ARM2:dgc_pkg::ACQ_ARM1];
endmodule
`default_nettype wire

// File: tb/dgc_regs_sva.sv
// port assertions for the digitizer register bank
`timescale 1ns/1ps
`default_nettype none
module dgc_regs_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic [31:0] regRdata,
  // events and controls
  input wire logic eventEnd,
  input wire logic bankEnd,
  input wire logic irqReq,
  input wire logic [2:0] clockSource,
  input wire logic gateMode,
  input wire logic multiEvent,
  input wire logic autoStart,
  input wire logic [1:0] bankArm
);
  wire acqWr = regWr && regAddr == dgc_pkg::OFS_ACQ;
  wire keyWr = regWr && regAddr == dgc_pkg::OFS_RESET;
  wire [2:0] clkSet = regWdata[14:12];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_clk_set: assert property (
    acqWr && regWdata[30:28] == 3'h0 |=>
    (clockSource & $past(clkSet)) == $past(clkSet)) else $error("clk set");
  a_clk_clear: assert property (
    acqWr |=> (clockSource & $past(regWdata[30:28])) == 3'h0)
    else $error("clk clear");
  a_gate_mode: assert property (
    acqWr && (regWdata[10] || regWdata[26]) |=>
    gateMode == !$past(regWdata[26])) else $error("gate mode");
  a_multi_mode: assert property (
    acqWr && (regWdata[5] || regWdata[21]) |=>
    multiEvent == !$past(regWdata[21])) else $error("multi mode");
  a_auto_multi: assert property (
    autoStart |-> multiEvent) else $error("autostart alone");
  a_disarm_event: assert property (
    eventEnd && !multiEvent |=> bankArm == 2'h0) else $error("event disarm");
  a_disarm_bank: assert property (
    bankEnd && multiEvent |=> bankArm == 2'h0) else $error("bank disarm");
  a_reset_key: assert property (
    keyWr |-> ##2 clockSource == 3'h0 && bankArm == 2'h0 && !multiEvent
    && !irqReq) else $error("reset key");
  a_rdata_hold: assert property (
    !regRd |=> $stable(regRdata)) else $error("read data moved");
endmodule
bind dgc_regs dgc_regs_chk chk (.clk, .rst, .regWr, .regRd, .regAddr,
  .regWdata, .regRdata, .eventEnd, .bankEnd, .irqReq, .clockSource,
  .gateMode, .multiEvent, .autoStart, .bankArm);
`default_nettype wire

// File: tb/dgc_host_model.sv
// host processor model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module dgc_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic regWr = 1'b0,
  output logic regRd = 1'b0,
  output logic [7:0] regAddr = 8'h00,
  output logic [31:0] regWdata = 32'h00000000,
  input wire logic [31:0] regRdata,
  // acknowledge
  output logic irqAck = 1'b0
);
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    regWdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic ack();
    @(posedge clk);
    irqAck <= 1'b1;
    @(posedge clk);
    irqAck <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the digitizer register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] ACQ = dgc_pkg::OFS_ACQ;
  localparam logic [7:0] ICT = dgc_pkg::OFS_ICTL;
  localparam logic [7:0] CFG = dgc_pkg::OFS_ICFG;
  logic clk = 1'b0;
  logic rst = 1'b1;
  // eventEnd, bankEnd, userIn, adcBusy, extStart, extStop
  logic [5:0] ev = 6'h00;
  logic regWr, regRd, irqAck, irqReq, gateMode, bpSs, fpSs;
  logic multiEvent, autoStart, startOut, stopOut;
  logic [7:0] regAddr, irqVector;
  logic [31:0] regWdata, regRdata, d;
  logic [2:0] irqLevel, clockSource;
  logic [1:0] bankArm;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  always #5 clk = ~clk;
  dgc_host_model host (.clk(clk), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .irqAck(irqAck));
  dgc_regs uut (.clk(clk), .rst(rst), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .irqAck(irqAck), .irqReq(irqReq), .irqLevel(irqLevel),
    .irqVector(irqVector), .eventEnd(ev[0]), .bankEnd(ev[1]),
    .userIn(ev[2]), .adcBusy(ev[3]), .extStart(ev[4]), .extStop(ev[5]),
    .clockSource(clockSource), .gateMode(gateMode),
    .backplaneStartStop(bpSs), .frontStartStop(fpSs),
    .multiEvent(multiEvent), .autoStart(autoStart), .bankArm(bankArm),
    .startOut(startOut), .stopOut(stopOut));
  task automatic check(input string what, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
    host.rd(a, d);
    check("readback", d, exp);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask
  // edges from the one taking the pulse to the one sampling the output
  task automatic measure(input int which, output int cnt);
    pulse(4 + which);
    cnt = 0;
    #1;
    while (!(which ? stopOut : startOut) && cnt < 40) begin
      @(posedge clk);
      #1 cnt++;
    end
    // launched after edge cnt, sampled at the next one
    cnt++;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdx(ICT, 32'h00000000);
    ev[3] <= 1'b1;
    rdx(ACQ, 32'h00010000);
    ev[3] <= 1'b0;
    host.wr(ACQ, 32'h0000ffff);
    rdx(ACQ, 32'h000077f3);
    check("ctl", {clockSource, gateMode, bpSs, fpSs, multiEvent, autoStart,
      bankArm}, 32'h3ff);
    host.wr(ACQ, 32'h04000400);
    rdx(ACQ, 32'h000073f3);
    host.wr(ACQ, 32'hffff0000);
    rdx(ACQ, 32'h00000000);
    for (int c = 0; c < 8; c++) begin
      host.wr(ACQ, 32'h70000000);
      host.wr(ACQ, 32'(c) << 12);
      rdx(ACQ, 32'(c) << 12);
    end
    host.wr(ACQ, 32'h70000003);
    pulse(0);
    #1 check("arm", 32'(bankArm), 32'h0);
    host.wr(ACQ, 32'h00000023);
    pulse(0);
    #1 check("arm", 32'(bankArm), 32'h3);
    pulse(1);
    #1 check("arm", 32'(bankArm), 32'h0);
    host.wr(ACQ, 32'h00200010);
    check("auto", 32'(autoStart), 32'h0);
    host.wr(ACQ, 32'h00000020);
    check("auto", 32'(autoStart), 32'h1);
    host.wr(CFG, 32'h00000b55);
    check("cfg", 32'({irqLevel, irqVector}), 32'h355);
    host.wr(ICT, 32'h000f0000);
    rdx(ICT, 32'h00000000);
    host.wr(ICT, 32'h0000000f);
    rdx(ICT, 32'h0000000f);
    pulse(0);
    rdx(ICT, 32'h1c00000f);
    check("irq", 32'(irqReq), 32'h1);
    host.wr(ICT, 32'h00010000);
    rdx(ICT, 32'h0000000e);
    pulse(2);
    rdx(ICT, 32'h8c00000e);
    host.wr(CFG, 32'h00001b55);
    host.ack();
    rdx(ICT, 32'h00000006);
    host.wr(CFG, 32'h00000355);
    host.wr(ICT, 32'h00000008);
    pulse(2);
    rdx(ICT, 32'h8400000e);
    check("irq", 32'(irqReq), 32'h0);
    host.wr(dgc_pkg::OFS_SDLY, 32'h00000003);
    host.wr(ACQ, 32'h00400080);
    measure(0, n);
    check("start", n, 5);
    measure(1, n);
    check("stop", n, 1);
    host.wr(8'h40, 32'hffffffff);
    rdx(ACQ, 32'h000000b0);
    host.wr(dgc_pkg::OFS_RESET, 32'h00000000);
    rdx(ACQ, 32'h00000000);
    rdx(ICT, 32'h00000000);
    check("cfg", 32'({irqLevel, irqVector}), 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
